// >>> tb/sbdc_host_model.sv
/*
  Host controller model: step clock, reset pin and enable pin.
  Assumes the bench calls its tasks; pins change right after clock edges.
*/
`timescale 1ns/1ns
module sbdc_host_model (
   input  wire logic clk_i,       // Logic clock
   output logic      step_clk_o,  // Step clock, low outside pulses
   output logic      reset_n_o,   // Host reset pin
   output logic      enable_o     // Host enable pin
);
   // All control pins held low through power-up
   initial begin
      step_clk_o = 1'b0;
      reset_n_o  = 1'b0;
      enable_o   = 1'b0;
   end
   // Set both level pins at one edge
   task automatic set_pins(input logic rn, input logic en);
      @(posedge clk_i);
      reset_n_o <= rn;
      enable_o  <= en;
   endtask
   // Step pulses of 48 ns: 6 cycles high, 6 low
   task automatic steps(input int n);
      repeat (n) begin
         @(posedge clk_i);
         step_clk_o <= 1'b1;
         repeat (6) @(posedge clk_i);
         step_clk_o <= 1'b0;
         repeat (5) @(posedge clk_i);
      end
   endtask
   // Enable drops first, reset pin after it
   task automatic power_down();
      set_pins(reset_n_o, 1'b0);
      set_pins(1'b0, 1'b0);
   endtask
endmodule

// >>> tb/sbdc_top_props.sv
/*
  Checker for the bridge gate drive and open-drain outputs of sbdc_top.
  Assumes one clock domain and binding to the top module's ports.
*/
`timescale 1ns/1ns
module sbdc_props (
   input wire logic REF_CLK_I,        // Logic clock
   input wire logic RST_I,            // Block reset
   input wire logic RESET_N_I,        // Host reset pin
   input wire logic ENABLE_I,         // Host enable pin
   input wire logic THERMAL_TRIP_I,   // Thermal trip
   input wire logic HIGH_SWITCH_A_O,  // Gate drives
   input wire logic HIGH_SWITCH_B_O,
   input wire logic LOW_SWITCH_A_O,
   input wire logic LOW_SWITCH_B_O,
   input wire logic INIT_FLAG_O,      // Open-drain levels and enables
   input wire logic INIT_FLAG_OE_O,
   input wire logic FAULT_O,
   input wire logic FAULT_OE_O
);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   logic [3:0] g;  // Gate pattern, high A, high B, low A, low B
   assign g = {HIGH_SWITCH_A_O, HIGH_SWITCH_B_O, LOW_SWITCH_A_O, LOW_SWITCH_B_O};
   // A driven pattern drops to all off, then off holds
   sequence s_gate_drop; g != 4'h0 ##1 g == 4'h0; endsequence
   sequence s_stay_off; (g == 4'h0)[*8]; endsequence
   property p_dead_hold; s_gate_drop |-> s_stay_off; endproperty
   // Only a change to the complementary pattern may skip the off interval
   property p_no_direct;
      g != 4'h0 && $past(g) != 4'h0 && g != $past(g) |-> (g ^ $past(g)) == 4'hf;
   endproperty
   property p_short_a; !(HIGH_SWITCH_A_O && LOW_SWITCH_A_O); endproperty
   property p_short_b; !(HIGH_SWITCH_B_O && LOW_SWITCH_B_O); endproperty
   property p_en_off; (!ENABLE_I)[*5] |-> g == 4'h0; endproperty
   property p_pin_rst; (!RESET_N_I)[*5] |-> g == 4'h0 && INIT_FLAG_OE_O; endproperty
   property p_therm; THERMAL_TRIP_I[*5] |-> g == 4'h0 && FAULT_OE_O; endproperty
   property p_cool; (!THERMAL_TRIP_I)[*5] |-> !FAULT_OE_O; endproperty
   property p_od_low; !INIT_FLAG_O && !FAULT_O; endproperty
   a_dead_hold: assert property (p_dead_hold) else $error("gates back inside dead interval");
   a_no_direct: assert property (p_no_direct) else $error("mode change without dead interval");
   a_short_a: assert property (p_short_a) else $error("shoot-through on leg A");
   a_short_b: assert property (p_short_b) else $error("shoot-through on leg B");
   a_en_off: assert property (p_en_off) else $error("gates on with enable low");
   a_pin_rst: assert property (p_pin_rst) else $error("gates on or flag idle in reset");
   a_therm: assert property (p_therm) else $error("gates on or fault idle when hot");
   a_cool: assert property (p_cool) else $error("fault pulled low when cool");
   a_od_low: assert property (p_od_low) else $error("open-drain level not low");
endmodule

bind sbdc_top sbdc_props u_props (.REF_CLK_I, .RST_I, .RESET_N_I, .ENABLE_I, .THERMAL_TRIP_I,
   .HIGH_SWITCH_A_O, .HIGH_SWITCH_B_O, .LOW_SWITCH_A_O, .LOW_SWITCH_B_O,
   .INIT_FLAG_O, .INIT_FLAG_OE_O, .FAULT_O, .FAULT_OE_O);

// >>> tb/test_stepper_bridge_drive_control.sv
/*
  Self-checking bench for the stepper bridge drive control block.
  Assumes the package, sbdc_top, the host model and the checker compile first.
*/
`timescale 1ns/1ns
module test_stepper_bridge_drive_control;
   logic                 ref_clk;  // 250 MHz clock
   logic                 rst;      // Block reset
   logic                 thermal;  // Thermal trip drive
   logic [11:0]          chop;     // Chop wave, mV
   logic [7:0]           addr;     // Register port
   logic [31:0]          wdata;
   logic                 wr;
   logic                 rd;
   logic [31:0]          rdata;
   logic                 step_clk; // Host pins
   logic                 reset_n;
   logic                 enable;
   logic                 init_oe;
   logic                 fault_oe;
   logic                 irq;
   sbdc_pkg::sbdc_gate_t gate;     // Gate outputs
   logic [31:0]          d;        // Last read word
   int                   num_errors;
   int                   tests_run;
   // Chop wave steps and chop counts expected after each
   logic [11:0] cv [6] = '{12'h7cf, 12'h7d0, 12'h1f5, 12'h7d0, 12'h1f4, 12'h7d0};
   logic [7:0]  ce [6] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h1};
   // Mode requests and gate patterns, forward then reverse, then spare code 3 as slow
   logic [2:0]  mq [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
   logic [3:0]  mx [7] = '{4'h9, 4'h3, 4'h6, 4'h6, 4'h3, 4'h9, 4'h3};

   sbdc_top u_dut (
      .REF_CLK_I(ref_clk), .RST_I(rst), .STEP_CLK_I(step_clk), .RESET_N_I(reset_n),
      .ENABLE_I(enable), .THERMAL_TRIP_I(thermal), .CHOP_WAVE_I(chop), .BUS_ADDR_I(addr),
      .BUS_WDATA_I(wdata), .BUS_WR_I(wr), .BUS_RD_I(rd), .BUS_RDATA_O(rdata),
      .HIGH_SWITCH_A_O(gate.high_switch_a), .HIGH_SWITCH_B_O(gate.high_switch_b),
      .LOW_SWITCH_A_O(gate.low_switch_a), .LOW_SWITCH_B_O(gate.low_switch_b), .INIT_FLAG_O(),
      .INIT_FLAG_OE_O(init_oe), .FAULT_O(), .FAULT_OE_O(fault_oe), .IRQ_O(irq));
   sbdc_host_model u_host (.clk_i(ref_clk), .step_clk_o(step_clk), .reset_n_o(reset_n), .enable_o(enable));

   // Clock generator
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Wait n edges and let them settle
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // One-cycle register write
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask
   // One-cycle register read, data taken in the following cycle
   task automatic bus_rd(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask
   // Set the chop wave level, then wait
   task automatic wave(input logic [11:0] v, input int n);
      @(posedge ref_clk);
      chop <= v;
      tick(n);
   endtask
   // Word compare
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Gate pattern compare, high A, high B, low A, low B
   task automatic chk_gate(input logic [3:0] e);
      chk_word("gates", {28'h0, e}, {28'h0, gate});
   endtask
   // Verdict and end of run
   task automatic tally_and_finish();
      if (num_errors == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog, far beyond the expected run of some 2400 cycles
   initial begin
      #100000;
      num_errors++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      thermal = 1'b0;
      chop = 12'h000;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      num_errors = 0;
      tests_run = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      // Reset values and an unmapped place
      bus_rd(sbdc_pkg::REG_CTRL);
      chk_word("ctrl", 32'h1, d);
      tick(1);
      chk_word("rdata idle", 32'h0, rdata);
      bus_rd(sbdc_pkg::REG_MASK);
      chk_word("mask", 32'h0, d);
      bus_rd(8'h10);
      chk_word("unmapped", 32'h0, d);
      // Enable with reset pin low: steps ignored
      u_host.set_pins(1'b0, 1'b1);
      u_host.steps(2);
      bus_rd(sbdc_pkg::REG_STATE);
      chk_word("step count", 32'h0, {24'h0, d[23:16]});
      chk_word("init flag", 32'h1, {31'h0, init_oe});
      chk_gate(4'h0);
      // Reset pin high, enable low: count runs, gates off
      u_host.set_pins(1'b1, 1'b0);
      tick(4);
      u_host.steps(3);
      bus_rd(sbdc_pkg::REG_STATE);
      chk_word("step count", 32'h3, {24'h0, d[23:16]});
      chk_gate(4'h0);
      chk_word("init flag", 32'h0, {31'h0, init_oe});
      bus_rd(sbdc_pkg::REG_STATUS);
      chk_word("restart", 32'h0, {31'h0, d[sbdc_pkg::EV_RESTART]});
      // Chop clock thresholds and counter restart
      foreach (cv[i]) begin
         wave(cv[i], 6);
         bus_rd(sbdc_pkg::REG_STATE);
         chk_word("chop count", {24'h0, ce[i]}, {24'h0, d[31:24]});
      end
      bus_rd(sbdc_pkg::REG_STATUS);
      chk_word("restart", 32'h1, {31'h0, d[sbdc_pkg::EV_RESTART]});
      // Drive on: every mode both ways, off interval first
      wave(12'h000, 2);
      u_host.set_pins(1'b1, 1'b1);
      tick(400);
      chk_gate(4'h3);
      for (int i = 0; i < 7; i++) begin
         bus_wr(sbdc_pkg::REG_CTRL, {29'h0, mq[i]});
         tick(40);
         chk_gate(4'h0);
         tick(100);
         chk_gate(mx[i]);
      end
      // Step in slow decay, then a chop rise: brief charge
      bus_wr(sbdc_pkg::REG_CTRL, 32'h1);
      bus_wr(sbdc_pkg::REG_STATUS, 32'h7);
      tick(100);
      u_host.steps(1);
      wave(sbdc_pkg::CHOP_HI_MV, 150);
      chk_gate(4'h9);
      tick(300);
      chk_gate(4'h3);
      // Interrupt masked, raised and cleared
      chk_word("irq", 32'h0, {31'h0, irq});
      bus_wr(sbdc_pkg::REG_MASK, 32'h2);
      tick(2);
      chk_word("irq", 32'h1, {31'h0, irq});
      bus_wr(sbdc_pkg::REG_STATUS, 32'h2);
      tick(2);
      chk_word("irq", 32'h0, {31'h0, irq});
      // Thermal trip
      wave(12'h000, 2);
      @(posedge ref_clk);
      thermal <= 1'b1;
      tick(8);
      chk_gate(4'h0);
      chk_word("fault", 32'h1, {31'h0, fault_oe});
      bus_rd(sbdc_pkg::REG_STATUS);
      chk_word("thermal", 32'h1, {31'h0, d[sbdc_pkg::EV_THERMAL]});
      @(posedge ref_clk);
      thermal <= 1'b0;
      tick(200);
      chk_gate(4'h3);
      // Enable loss, power-down order, reset pin back to the initial state
      u_host.set_pins(1'b1, 1'b0);
      tick(6);
      chk_gate(4'h0);
      u_host.power_down();
      tick(6);
      bus_rd(sbdc_pkg::REG_STATE);
      chk_word("step count", 32'h0, {24'h0, d[23:16]});
      chk_word("init flag", 32'h1, {31'h0, init_oe});
      u_host.set_pins(1'b1, 1'b1);
      tick(4);
      u_host.steps(1);
      bus_rd(sbdc_pkg::REG_STATE);
      chk_word("step count", 32'h1, {24'h0, d[23:16]});
      tally_and_finish();
   end
endmodule

// >>> verilog/sbdc_pkg.sv
/*
  Package for the stepper bridge drive control block: register map, field
  positions, reset values, timing counts and the shared types.
  Assumes a 250 MHz logic clock and a 32-bit plain register port.
*/
package sbdc_pkg;

   // Clock and timing
   localparam int CLK_PERIOD_NS  = 4;                                // Logic clock period
   localparam int DEAD_TIME_NS   = 300;                              // Dead interval between modes
   localparam int DEAD_CYC       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SENSE_TIME_NS  = 1000;                             // Brief charge for current sensing
   localparam int SENSE_CYC      = (SENSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] DEAD_CNT_INIT  = 8'(DEAD_CYC - 1);         // Dead counter load value
   localparam logic [9:0] SENSE_CNT_INIT = 10'(SENSE_CYC - 1);       // Sense counter load value

   // Chop wave thresholds, in millivolts, 12-bit code
   localparam logic [11:0] CHOP_HI_MV = 12'h7d0;                     // 2000 mV, go high
   localparam logic [11:0] CHOP_LO_MV = 12'h1f4;                     // 500 mV, go low

   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;                        // Mode request and direction
   localparam logic [7:0] REG_STATUS = 8'h04;                        // Sticky events, write one to clear
   localparam logic [7:0] REG_MASK   = 8'h08;                        // Interrupt mask
   localparam logic [7:0] REG_STATE  = 8'h0c;                        // Live state, read only

   // CTRL fields
   localparam int CTRL_MODE_LSB = 0;                                 // Requested mode, 2 bits
   localparam int CTRL_DIR_BIT  = 2;                                 // 1 = reverse current
   localparam logic [2:0] CTRL_RESET = 3'h1;                         // Slow decay, forward

   // STATUS and MASK fields
   localparam int EV_THERMAL = 0;                                    // Thermal trip asserted
   localparam int EV_STEP    = 1;                                    // Accepted step edge
   localparam int EV_RESTART = 2;                                    // Chop counter restarted
   localparam int EV_W       = 3;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Requested mode codes in CTRL
   localparam logic [1:0] REQ_CHARGE = 2'h0;
   localparam logic [1:0] REQ_SLOW   = 2'h1;
   localparam logic [1:0] REQ_FAST   = 2'h2;

   // Drive modes, one-hot
   typedef enum logic [2:0] {
      SBDC_CHARGE = 3'b001,
      SBDC_SLOW   = 3'b010,
      SBDC_FAST   = 3'b100
   } sbdc_mode_t;

   // Dead-time sequencer states, one-hot
   typedef enum logic [1:0] {
      SBDC_RUN  = 2'b01,
      SBDC_DEAD = 2'b10
   } sbdc_seq_t;

   // The four bridge switches
   typedef struct packed {
      logic high_switch_a;
      logic high_switch_b;
      logic low_switch_a;
      logic low_switch_b;
   } sbdc_gate_t;

   localparam sbdc_gate_t GATE_OFF = 4'h0;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } sbdc_bus_t;

endpackage

// >>> verilog/sbdc_top.sv
/*
  Stepper bridge drive control for one motor phase: mode to switch mapping,
  dead time, chop clock thresholding, chop counter restart, step counter,
  gating by reset, enable and thermal trip, register port and interrupt.
  Assumes step clock, reset, enable and thermal trip pins are asynchronous;
  the chop wave code comes from a converter on REF_CLK_I.
*/
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns

//  Operation
// - Forward current switch patterns per mode
// - Reverse current switch patterns per mode
// - Dead interval of 300 ns on change
// - Chop clock hysteresis at 2 V, 0.5 V
// - Drive only when reset released and enabled
// - Enable low: outputs off, counter advances
// - Reset low: step edges ignored
// - Thermal trip turns all switches off
// - Enable loss forces all switches off
// - Step edge or reversal restarts chop counter; only step edges request it, a CTRL direction change alone does not
// - Reset low forces initial state, flag low
// - Restart waits for next chop rising edge
// - Brief charge after restart and each period
// - Thermal trip pulls fault output low
module sbdc_top (
   input  wire logic        REF_CLK_I,          // Logic clock, 250 MHz
   input  wire logic        RST_I,              // Asynchronous reset, active high
   input  wire logic        STEP_CLK_I,         // Step clock pin from host
   input  wire logic        RESET_N_I,          // Host reset pin, low resets
   input  wire logic        ENABLE_I,           // Host enable pin
   input  wire logic        THERMAL_TRIP_I,     // Thermal trip indication
   input  wire logic [11:0] CHOP_WAVE_I,        // Chop wave level in mV
   input  wire logic [7:0]  BUS_ADDR_I,         // Register address
   input  wire logic [31:0] BUS_WDATA_I,        // Register write data
   input  wire logic        BUS_WR_I,           // Write strobe
   input  wire logic        BUS_RD_I,           // Read strobe
   output logic      [31:0] BUS_RDATA_O,        // Read data, cycle after strobe
   output logic             HIGH_SWITCH_A_O,    // Bridge gate drives
   output logic             HIGH_SWITCH_B_O,
   output logic             LOW_SWITCH_A_O,
   output logic             LOW_SWITCH_B_O,
   output logic             INIT_FLAG_O,        // Open-drain level, always low
   output logic             INIT_FLAG_OE_O,     // High while pulling flag low
   output logic             FAULT_O,            // Open-drain level, always low
   output logic             FAULT_OE_O,         // High while pulling fault low
   output logic             IRQ_O               // Level interrupt
);

   // Pattern for a mode and current direction
   function automatic sbdc_pkg::sbdc_gate_t gate_of(input sbdc_pkg::sbdc_mode_t m, input logic rev);
      sbdc_pkg::sbdc_gate_t g;
      g = sbdc_pkg::GATE_OFF;
      case (m)
         sbdc_pkg::SBDC_CHARGE: begin
            g.high_switch_a = !rev;
            g.low_switch_b  = !rev;
            g.high_switch_b = rev;
            g.low_switch_a  = rev;
         end
         sbdc_pkg::SBDC_SLOW: begin
            g.low_switch_a = 1'b1;
            g.low_switch_b = 1'b1;
         end
         sbdc_pkg::SBDC_FAST: begin
            g.high_switch_b = !rev;
            g.low_switch_a  = !rev;
            g.high_switch_a = rev;
            g.low_switch_b  = rev;
         end
         default: g = sbdc_pkg::GATE_OFF;
      endcase
      return g;
   endfunction

   // Requested mode code to one-hot mode
   function automatic sbdc_pkg::sbdc_mode_t mode_of(input logic [1:0] code);
      case (code)
         sbdc_pkg::REQ_CHARGE: return sbdc_pkg::SBDC_CHARGE;
         sbdc_pkg::REQ_FAST:   return sbdc_pkg::SBDC_FAST;
         default:              return sbdc_pkg::SBDC_SLOW;
      endcase
   endfunction

   // Synchronisers for asynchronous pins
   logic [3:0]  meta_ff;                   // First stage, read only by sync_ff
   logic [3:0]  sync_ff;                   // Second stage: step, reset_n, enable, thermal
   logic        step_d_ff;                 // Delayed step for edge detect
   logic        thermal_d_ff;              // Delayed thermal for event
   // Registers
   logic [2:0]  ctrl_ff;                   // Mode request and direction
   logic [2:0]  status_ff;                 // Sticky events
   logic [2:0]  mask_ff;                   // Interrupt mask
   logic [31:0] rdata_ff;                  // Read data
   // Core state
   logic        chop_clk_ff;               // Thresholded chop clock
   logic        chop_d_ff;                 // Delayed chop clock
   logic [7:0]  chop_cnt_ff;               // Chop counter
   logic        restart_pend_ff;           // Restart waiting for chop edge
   logic        last_dir_ff;               // Direction at the last step
   logic [9:0]  sense_cnt_ff;              // Remaining sense charge cycles
   logic        sense_ff;                  // Sense charge active
   logic [7:0]  step_cnt_ff;               // Step position counter
   sbdc_pkg::sbdc_seq_t  seq_ff;           // Dead-time sequencer state
   logic [7:0]  dead_cnt_ff;               // Dead interval counter
   sbdc_pkg::sbdc_mode_t applied_ff;       // Mode whose pattern is on
   sbdc_pkg::sbdc_gate_t gate_ff;          // Registered gate drives
   logic        init_oe_ff;                // Initial flag pull-down
   logic        fault_oe_ff;               // Fault pull-down
   logic        irq_ff;                    // Interrupt output

   // Decoded signals
   logic        step_s;                    // Synchronised step clock
   logic        rst_pin_n;                 // Synchronised host reset, low resets
   logic        enable_s;                  // Synchronised enable
   logic        thermal_s;                 // Synchronised thermal trip
   logic        step_rise;                 // Accepted rising step edge
   logic        chop_rise;                 // Chop clock rising edge
   logic        restart;                   // Chop counter restart now
   logic        drive_ok;                  // Bridge may be driven
   logic        dir_s;                     // Current direction
   logic [2:0]  events;                    // Event pulses
   sbdc_pkg::sbdc_mode_t target;           // Mode wanted now

   assign step_s    = sync_ff[0];
   assign rst_pin_n = sync_ff[1];
   assign enable_s  = sync_ff[2];
   assign thermal_s = sync_ff[3];
   assign dir_s     = ctrl_ff[sbdc_pkg::CTRL_DIR_BIT];
   // Steps are taken only while the host reset is released
   assign step_rise = step_s && !step_d_ff && rst_pin_n;
   assign chop_rise = chop_clk_ff && !chop_d_ff;
   // A pending restart lands only on a chop rising edge
   assign restart   = restart_pend_ff && chop_rise;
   // Drive needs reset released, enable high and no thermal trip
   assign drive_ok  = rst_pin_n && enable_s && !thermal_s;
   // Sense charge overrides the requested mode
   assign target    = sense_ff ? sbdc_pkg::SBDC_CHARGE
                               : mode_of(ctrl_ff[sbdc_pkg::CTRL_MODE_LSB +: 2]);

   always_comb begin
      events = '0;
      events[sbdc_pkg::EV_THERMAL] = thermal_s && !thermal_d_ff;
      events[sbdc_pkg::EV_STEP]    = step_rise;
      events[sbdc_pkg::EV_RESTART] = restart;
   end

   // Two-stage synchronisers and edge history
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         meta_ff      <= 4'h0;
         sync_ff      <= 4'h0;
         step_d_ff    <= 1'b0;
         thermal_d_ff <= 1'b0;
      end else begin
         meta_ff      <= {THERMAL_TRIP_I, ENABLE_I, RESET_N_I, STEP_CLK_I};
         sync_ff      <= meta_ff;
         step_d_ff    <= step_s;
         thermal_d_ff <= thermal_s;
      end
   end

   // Chop clock with hysteresis between the two thresholds
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         chop_clk_ff <= 1'b0;
         chop_d_ff   <= 1'b0;
      end else begin
         if (CHOP_WAVE_I >= sbdc_pkg::CHOP_HI_MV) begin
            chop_clk_ff <= 1'b1;
         end else if (CHOP_WAVE_I <= sbdc_pkg::CHOP_LO_MV) begin
            chop_clk_ff <= 1'b0;
         end
         chop_d_ff <= chop_clk_ff;
      end
   end

   // Restart request and chop counter
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         restart_pend_ff <= 1'b0;
         last_dir_ff     <= 1'b0;
         chop_cnt_ff     <= 8'h00;
      end else begin
         // Any accepted step, in any mode or on a reversal, asks for a restart
         if (step_rise) begin
            restart_pend_ff <= 1'b1;
            last_dir_ff     <= dir_s;
         end else if (restart) begin
            restart_pend_ff <= 1'b0;
         end
         // Counter restarts to zero, otherwise counts chop periods
         if (restart) begin
            chop_cnt_ff <= 8'h00;
         end else if (chop_rise) begin
            chop_cnt_ff <= chop_cnt_ff + 8'h01;
         end
      end
   end

   // Brief charge window at every chop period, restart included
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sense_ff     <= 1'b0;
         sense_cnt_ff <= 10'h000;
      end else begin
         if (chop_rise) begin
            sense_ff     <= 1'b1;
            sense_cnt_ff <= sbdc_pkg::SENSE_CNT_INIT;
         end else if (sense_cnt_ff != 10'h000) begin
            sense_cnt_ff <= sense_cnt_ff - 10'h001;
         end else begin
            sense_ff <= 1'b0;
         end
      end
   end

   // Step counter keeps running with enable low, held at zero in reset
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         step_cnt_ff <= 8'h00;
      end else if (!rst_pin_n) begin
         step_cnt_ff <= 8'h00;
      end else if (step_rise) begin
         step_cnt_ff <= step_cnt_ff + 8'h01;
      end
   end

   // Mode sequencer with dead interval on every change
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         seq_ff      <= sbdc_pkg::SBDC_RUN;
         dead_cnt_ff <= 8'h00;
         applied_ff  <= sbdc_pkg::SBDC_SLOW;
      end else begin
         case (seq_ff)
            sbdc_pkg::SBDC_RUN: begin
               if (target != applied_ff) begin
                  seq_ff      <= sbdc_pkg::SBDC_DEAD;
                  dead_cnt_ff <= sbdc_pkg::DEAD_CNT_INIT;
               end
            end
            sbdc_pkg::SBDC_DEAD: begin
               if (dead_cnt_ff != 8'h00) begin
                  dead_cnt_ff <= dead_cnt_ff - 8'h01;
               end else begin
                  seq_ff     <= sbdc_pkg::SBDC_RUN;
                  applied_ff <= target;
               end
            end
            default: begin
               seq_ff <= sbdc_pkg::SBDC_RUN;
            end
         endcase
      end
   end

   // Gate drives: off when not allowed or during the dead interval
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         gate_ff <= sbdc_pkg::GATE_OFF;
      end else if (!drive_ok) begin
         gate_ff <= sbdc_pkg::GATE_OFF;
      end else if (seq_ff != sbdc_pkg::SBDC_RUN || target != applied_ff) begin
         gate_ff <= sbdc_pkg::GATE_OFF;
      end else begin
         gate_ff <= gate_of(applied_ff, dir_s);
      end
   end

   // Open-drain flags
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         init_oe_ff  <= 1'b0;
         fault_oe_ff <= 1'b0;
      end else begin
         init_oe_ff  <= (step_cnt_ff == 8'h00) || !rst_pin_n;
         fault_oe_ff <= thermal_s;
      end
   end

   // Software registers; hardware set wins over write-one clear
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ctrl_ff   <= sbdc_pkg::CTRL_RESET;
         mask_ff   <= sbdc_pkg::MASK_RESET;
         status_ff <= 3'h0;
      end else begin
         if (BUS_WR_I && BUS_ADDR_I == sbdc_pkg::REG_CTRL) begin
            ctrl_ff <= BUS_WDATA_I[2:0];
         end
         if (BUS_WR_I && BUS_ADDR_I == sbdc_pkg::REG_MASK) begin
            mask_ff <= BUS_WDATA_I[2:0];
         end
         if (BUS_WR_I && BUS_ADDR_I == sbdc_pkg::REG_STATUS) begin
            status_ff <= (status_ff & ~BUS_WDATA_I[2:0]) | events;
         end else begin
            status_ff <= status_ff | events;
         end
      end
   end

   // Read data for the cycle after the strobe; unmapped reads zero
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rdata_ff <= 32'h0000_0000;
      end else if (BUS_RD_I) begin
         case (BUS_ADDR_I)
            sbdc_pkg::REG_CTRL:   rdata_ff <= {29'h0, ctrl_ff};
            sbdc_pkg::REG_STATUS: rdata_ff <= {29'h0, status_ff};
            sbdc_pkg::REG_MASK:   rdata_ff <= {29'h0, mask_ff};
            sbdc_pkg::REG_STATE:  rdata_ff <= {chop_cnt_ff, step_cnt_ff, 7'h0, drive_ok,
                                               seq_ff == sbdc_pkg::SBDC_DEAD, sense_ff, applied_ff, thermal_s,
                                               enable_s, rst_pin_n};
            default:              rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // Interrupt level
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(status_ff & mask_ff);
      end
   end

   assign BUS_RDATA_O     = rdata_ff;
   assign HIGH_SWITCH_A_O = gate_ff.high_switch_a;
   assign HIGH_SWITCH_B_O = gate_ff.high_switch_b;
   assign LOW_SWITCH_A_O  = gate_ff.low_switch_a;
   assign LOW_SWITCH_B_O  = gate_ff.low_switch_b;
   assign INIT_FLAG_O     = 1'b0;
   assign INIT_FLAG_OE_O  = init_oe_ff;
   assign FAULT_O         = 1'b0;
   assign FAULT_OE_O      = fault_oe_ff;
   assign IRQ_O           = irq_ff;

endmodule
